// *** tmr16_pkg.sv ***
// Package: register map, field positions and reset values of the timer control block
// ****************************************************************
// ****************************************************************
package tmr16_pkg;
	// Register byte addresses
	localparam logic [15:0] ADDR_TCS    = 16'hFF40;   // Timer clock select
	localparam logic [15:0] ADDR_TMC    = 16'hFF48;   // Timer mode control
	localparam logic [15:0] ADDR_TOC    = 16'hFF4E;   // Timer output control
	localparam logic [15:0] ADDR_P3DIR  = 16'hFF23;   // Port 3 direction
	localparam logic [15:0] ADDR_P3LAT  = 16'hFF03;   // Port 3 output latch
	localparam logic [15:0] ADDR_EMS    = 16'hFFEC;   // Edge mode select
	localparam logic [15:0] ADDR_CMP_LO = 16'hFF10;   // Compare register low byte
	localparam logic [15:0] ADDR_CMP_HI = 16'hFF11;   // Compare register high byte
	localparam logic [15:0] ADDR_CNT_LO = 16'hFF12;   // Count register low byte
	localparam logic [15:0] ADDR_CNT_HI = 16'hFF13;   // Count register high byte
	localparam logic [15:0] ADDR_CAP_LO = 16'hFF14;   // Capture register low byte
	localparam logic [15:0] ADDR_CAP_HI = 16'hFF15;   // Capture register high byte
	// Reset values
	localparam logic [7:0]  RST_ZERO    = 8'h00;
	localparam logic [7:0]  RST_P3DIR   = 8'hFF;
	localparam logic [7:0]  BYTE_MASK   = 8'hFF;
	localparam logic [15:0] CNT_MAX     = 16'hFFFF;
	// Field positions
	localparam int TCS_CNT_LSB = 4;                 // Count clock select 6:4
	localparam int TCS_CO_EN   = 7;                 // Clock output enable
	localparam int TMC_OVF     = 0;                 // Overflow flag
	localparam int TOC_OUT_EN  = 0;                 // Timer output enable
	localparam int TOC_LEVEL   = 1;                 // PWM active level (1 = low)
	localparam int TOC_INV_EN  = 2;                 // Inversion enable
	localparam int TOC_FF_CLR  = 3;                 // Flip-flop clear command
	localparam int TOC_FF_SET  = 4;                 // Flip-flop set command
	localparam logic [7:0] EMS_WMASK = 8'hFC;       // Bits 1:0 stay zero
	localparam logic [7:0] TOC_WMASK = 8'h07;       // Only stored control bits
	// Modes and encodings
	localparam logic [2:0] MODE_STOP = 3'h0;
	localparam logic [2:0] MODE_PWM  = 3'h1;
	localparam logic [1:0] CLR_EDGE  = 2'h2;
	localparam logic [1:0] CLR_MATCH = 2'h3;
	localparam logic [1:0] EDGE_FALL = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_BOTH = 2'h3;
	localparam logic [2:0] CSEL_PIN  = 3'h0;        // Count on input edges
	localparam logic [2:0] CSEL_MAX  = 3'h4;        // Last legal internal rate
	localparam int PWM_LSB = 2;                     // PWM uses upper 14 bits
	localparam int NUM_EXT = 3;                     // Shared input plus two irq pins
endpackage

// *** tmr16_edge_if.sv ***
// Interface: link between the controller and one valid-edge detector
`timescale 1ns/1ps
interface tmr16_edge_if;
	logic       sample_en;   // Sampling strobe
	logic [1:0] sel;         // Edge selection
	logic       pin_s;       // Synchronised pin level
	logic       edge_p;      // Accepted valid edge pulse
	modport det (input sample_en, input sel, input pin_s, output edge_p);
	modport ctl (output sample_en, output sel, output pin_s, input edge_p);
endinterface

// *** tmr16_edge_det.sv ***
// Module: noise-filtered valid-edge detector for one input pin
`timescale 1ns/1ps
module tmr16_edge_det
	import tmr16_pkg::*;
(
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic srst,
	// Controller side
	tmr16_edge_if.det e
);
	logic lvl_r;     // Accepted level
	logic lvl_nxt;
	logic smp_r;     // Previous sample
	logic smp_nxt;
	logic edg_r;     // Edge pulse
	logic edg_nxt;

	// ****************************************
	// Filter: a level counts after two equal samples
	// ****************************************
	always_comb
	begin
		lvl_nxt = lvl_r;
		smp_nxt = smp_r;
		edg_nxt = 1'b0;
		if (e.sample_en)
		begin
			smp_nxt = e.pin_s;
			// Short glitches never reach two samples
			if (e.pin_s == smp_r && e.pin_s != lvl_r)
			begin
				lvl_nxt = e.pin_s;
				case (e.sel)
					EDGE_FALL: edg_nxt = ~e.pin_s;
					EDGE_RISE: edg_nxt = e.pin_s;
					EDGE_BOTH: edg_nxt = 1'b1;
					default:   edg_nxt = 1'b0;   // Prohibited setting
				endcase
			end
		end
	end

	// Registers
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			lvl_r <= 1'b0;
			smp_r <= 1'b0;
			edg_r <= 1'b0;
		end
		else
		begin
			lvl_r <= lvl_nxt;
			smp_r <= smp_nxt;
			edg_r <= edg_nxt;
		end
	end

	assign e.edge_p = edg_r;

	a_edge_two_smp: assert property (@(posedge clk_sys) disable iff (srst)
		$rose(edg_r) |-> $past(e.sample_en) && $past(e.pin_s) == $past(smp_r))
		else $error("Edge accepted without two equal samples");
	a_edge_prohib: assert property (@(posedge clk_sys) disable iff (srst)
		$past(e.sel) == 2'h2 |-> !edg_r)
		else $error("Edge reported under prohibited selection");
	a_edge_rise: assert property (@(posedge clk_sys) disable iff (srst)
		edg_r && $past(e.sel) == EDGE_RISE |-> lvl_r)
		else $error("Rising selection reported a falling edge");
endmodule

// *** tmr16_ctrl.sv ***
// Module: 16-bit timer mode, clock select, output and edge control block
`timescale 1ns/1ps
module tmr16_ctrl
	import tmr16_pkg::*;
#(
	parameter int SAMPLE_DIV = 8   // Sampling strobe period in clocks
)
(
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        srst,
	// CPU register port
	input  wire logic [15:0] cpu_addr,
	input  wire logic        cpu_wr,
	input  wire logic [7:0]  cpu_wmask,
	input  wire logic [7:0]  cpu_wdata,
	input  wire logic        cpu_rd,
	output logic      [7:0]  cpu_rdata,
	// External pins
	input  wire logic        count_input_pin,
	input  wire logic        ext_irq_one_input,
	input  wire logic        ext_irq_two_input,
	output logic             timer_output_pin,
	output logic             timer_output_oe_n,
	output logic             clock_output_pin,
	// Interrupt requests
	output logic             compare_match_irq,
	output logic [2:0]       ext_irq_req
);
	import tmr16_pkg::*;

	if (SAMPLE_DIV < 2 || SAMPLE_DIV > 255)
	begin : g_chk
		$error("SAMPLE_DIV must be 2..255");
	end

	// Registers and next values
	logic [7:0]  tcs_r, tcs_nxt;         // Timer clock select
	logic [3:0]  tmc_r, tmc_nxt;         // Mode bits 3:1, overflow flag 0
	logic [2:0]  toc_r, toc_nxt;         // Stored output controls
	logic [7:0]  p3dir_r, p3dir_nxt;     // Port 3 direction
	logic [7:0]  p3lat_r, p3lat_nxt;     // Port 3 latch
	logic [7:0]  ems_r, ems_nxt;         // Edge mode select
	logic [15:0] cmp_r, cmp_nxt;         // Compare register
	logic [15:0] cnt_r, cnt_nxt;         // Count register
	logic [15:0] cap_r, cap_nxt;         // Capture register
	logic [15:0] pre_r, pre_nxt;         // Prescaler
	logic [7:0]  sdiv_r, sdiv_nxt;       // Sampling divider
	logic        ff_r, ff_nxt;           // Output flip-flop
	logic        to_r, to_nxt;           // Timer output pin
	logic        oen_r, oen_nxt;         // Timer output enable, low drives
	logic        co_r, co_nxt;           // Clock output pin
	logic        irq_r, irq_nxt;         // Compare match pulse
	logic [7:0]  rd_r, rd_nxt;           // Read data
	logic [2:0]  sy1_r, sy2_r;           // Pin synchronisers

	// Decoded state
	logic [2:0]  mode;
	logic        run, pwm, clr_edge, clr_match, out_on_edge;
	logic        tick, match, ti_edge, co_hit, pwm_act;
	logic [15:0] cmask, comask;
	logic [7:0]  wv;

	// ****************************************
	// Edge detectors, one per external pin
	// ****************************************
	tmr16_edge_if eif [NUM_EXT] ();
	for (genvar i = 0; i < NUM_EXT; i++)
	begin : g_det
		assign eif[i].sample_en = (sdiv_r == 8'h00);
		assign eif[i].sel       = ems_r[2*i+3 -: 2];
		assign eif[i].pin_s     = sy2_r[i];
		tmr16_edge_det u_det (
			.clk_sys (clk_sys),
			.srst    (srst),
			.e       (eif[i])
		);
	end
	assign ti_edge = eif[0].edge_p;

	// Two-stage pin synchronisers; only stage two is read
	always_ff @(posedge clk_sys)
	begin
		sy1_r <= {ext_irq_two_input, ext_irq_one_input, count_input_pin};
		sy2_r <= sy1_r;
	end

	// ****************************************
	// Mode decode and count clock
	// ****************************************
	always_comb
	begin
		mode        = tmc_r[3:1];
		run         = (mode != MODE_STOP);
		pwm         = (mode == MODE_PWM);
		clr_edge    = (mode[2:1] == CLR_EDGE);
		clr_match   = (mode[2:1] == CLR_MATCH);
		out_on_edge = (mode[2:1] != 2'h0) && mode[0];
		// Internal rates divide by 1, 2, 4 or 8
		cmask  = (16'h0001 << (tcs_r[6:4] - 3'h1)) - 16'h0001;
		comask = (16'h0002 << tcs_r[3:0]) - 16'h0001;
		co_hit = ((pre_r & comask) == comask);
		if (tcs_r[6:4] == CSEL_PIN)
			tick = ti_edge;
		else if (tcs_r[6:4] <= CSEL_MAX)
			tick = ((pre_r & cmask) == cmask);
		else
			tick = 1'b0;   // Prohibited selection holds the count
		match   = (cnt_r == cmp_r);
		pwm_act = (cnt_r[15:PWM_LSB] < cmp_r[15:PWM_LSB]);
	end

	// ****************************************
	// Register writes, counting and output control
	// ****************************************
	always_comb
	begin
		wv        = 8'h00;
		tcs_nxt   = tcs_r;
		tmc_nxt   = tmc_r;
		toc_nxt   = toc_r;
		p3dir_nxt = p3dir_r;
		p3lat_nxt = p3lat_r;
		ems_nxt   = ems_r;
		cmp_nxt   = cmp_r;
		cap_nxt   = cap_r;
		ff_nxt    = ff_r;
		pre_nxt   = pre_r + 16'h0001;
		sdiv_nxt  = (sdiv_r == 8'(SAMPLE_DIV - 1)) ? 8'h00 : sdiv_r + 8'h01;
		irq_nxt   = 1'b0;
		cnt_nxt   = cnt_r;
		// Counting
		if (!run)
			cnt_nxt = 16'h0000;
		else if (clr_edge && ti_edge)
			cnt_nxt = 16'h0000;
		else if (tick)
		begin
			if (clr_match && match)
				cnt_nxt = 16'h0000;
			else
				cnt_nxt = cnt_r + 16'h0001;
		end
		// Match request only while running
		if (run && tick && match)
			irq_nxt = 1'b1;
		// Capture on shared input edge
		if (run && ti_edge)
			cap_nxt = cnt_r;
		// Output flip-flop events outside PWM mode
		if (run && !pwm && toc_r[TOC_INV_EN])
		begin
			if ((tick && match) || (out_on_edge && ti_edge))
				ff_nxt = ~ff_r;
		end
		// CPU writes, masked for single-bit manipulation except the compare bytes and the byte-only edge register
		if (cpu_wr)
		begin
			case (cpu_addr)
				ADDR_TCS:
					tcs_nxt = (tcs_r & ~cpu_wmask) | (cpu_wdata & cpu_wmask);
				ADDR_TMC:
				begin
					wv = (8'(tmc_r) & ~cpu_wmask) | (cpu_wdata & cpu_wmask);
					tmc_nxt = wv[3:0];
				end
				ADDR_TOC:
				begin
					wv = (8'(toc_r) & ~cpu_wmask) | (cpu_wdata & cpu_wmask);
					toc_nxt = wv[2:0];
					if (cpu_wmask[TOC_FF_SET] && cpu_wdata[TOC_FF_SET])
						ff_nxt = 1'b1;
					else if (cpu_wmask[TOC_FF_CLR] && cpu_wdata[TOC_FF_CLR])
						ff_nxt = 1'b0;
				end
				ADDR_P3DIR:
					p3dir_nxt = (p3dir_r & ~cpu_wmask) | (cpu_wdata & cpu_wmask);
				ADDR_P3LAT:
					p3lat_nxt = (p3lat_r & ~cpu_wmask) | (cpu_wdata & cpu_wmask);
				ADDR_EMS:
					if (cpu_wmask == BYTE_MASK)
						ems_nxt = cpu_wdata & EMS_WMASK;
				ADDR_CMP_LO:
					cmp_nxt[7:0] = cpu_wdata;
				ADDR_CMP_HI:
					cmp_nxt[15:8] = cpu_wdata;
				default:
					wv = 8'h00;   // Unmapped writes are ignored
			endcase
		end
		// Overflow sets after the CPU clear so a same-cycle event wins
		if (run && tick && cnt_r == CNT_MAX && !(clr_match && match))
			tmc_nxt[TMC_OVF] = 1'b1;
		// Pin drives
		if (pwm)
			to_nxt = toc_r[TOC_OUT_EN] & (pwm_act ^ toc_r[TOC_LEVEL]);
		else
			to_nxt = toc_r[TOC_OUT_EN] & ff_r;
		to_nxt  = to_nxt | p3lat_r[0];
		oen_nxt = p3dir_r[0];
		co_nxt  = co_r;
		if (tcs_r[TCS_CO_EN] && co_hit)
			co_nxt = ~co_r;
		else if (!tcs_r[TCS_CO_EN])
			co_nxt = 1'b0;
		// Read data
		rd_nxt = rd_r;
		if (cpu_rd)
		begin
			case (cpu_addr)
				ADDR_TCS:    rd_nxt = tcs_r;
				ADDR_TMC:    rd_nxt = {4'h0, tmc_r};
				ADDR_TOC:    rd_nxt = {5'h00, toc_r};
				ADDR_P3DIR:  rd_nxt = p3dir_r;
				ADDR_P3LAT:  rd_nxt = p3lat_r;
				ADDR_EMS:    rd_nxt = ems_r;
				ADDR_CMP_LO: rd_nxt = cmp_r[7:0];
				ADDR_CMP_HI: rd_nxt = cmp_r[15:8];
				ADDR_CNT_LO: rd_nxt = cnt_r[7:0];
				ADDR_CNT_HI: rd_nxt = cnt_r[15:8];
				ADDR_CAP_LO: rd_nxt = cap_r[7:0];
				ADDR_CAP_HI: rd_nxt = cap_r[15:8];
				default:     rd_nxt = 8'h00;
			endcase
		end
	end

	// ****************************************
	// State registers
	// ****************************************
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			tcs_r   <= RST_ZERO;
			tmc_r   <= 4'h0;
			toc_r   <= 3'h0;
			p3dir_r <= RST_P3DIR;
			p3lat_r <= RST_ZERO;
			ems_r   <= RST_ZERO;
			cmp_r   <= 16'h0000;
			cnt_r   <= 16'h0000;
			cap_r   <= 16'h0000;
			pre_r   <= 16'h0000;
			sdiv_r  <= 8'h00;
			ff_r    <= 1'b0;
			to_r    <= 1'b0;
			oen_r   <= 1'b1;
			co_r    <= 1'b0;
			irq_r   <= 1'b0;
			rd_r    <= 8'h00;
		end
		else
		begin
			tcs_r   <= tcs_nxt;
			tmc_r   <= tmc_nxt;
			toc_r   <= toc_nxt;
			p3dir_r <= p3dir_nxt;
			p3lat_r <= p3lat_nxt;
			ems_r   <= ems_nxt;
			cmp_r   <= cmp_nxt;
			cnt_r   <= cnt_nxt;
			cap_r   <= cap_nxt;
			pre_r   <= pre_nxt;
			sdiv_r  <= sdiv_nxt;
			ff_r    <= ff_nxt;
			to_r    <= to_nxt;
			oen_r   <= oen_nxt;
			co_r    <= co_nxt;
			irq_r   <= irq_nxt;
			rd_r    <= rd_nxt;
		end
	end

	// External interrupt pulses, registered once more after the detector flops
	logic [2:0] xirq_r;
	always_ff @(posedge clk_sys)
	begin
		if (srst)
			xirq_r <= 3'h0;
		else
			xirq_r <= {eif[2].edge_p, eif[1].edge_p, eif[0].edge_p};
	end

	assign cpu_rdata         = rd_r;
	assign timer_output_pin  = to_r;
	assign timer_output_oe_n = oen_r;
	assign clock_output_pin  = co_r;
	assign compare_match_irq = irq_r;
	assign ext_irq_req       = xirq_r;

	// ****************************************
	// Checks
	// ****************************************
	a_stop_clears: assert property (@(posedge clk_sys) disable iff (srst)
		$past(tmc_r[3:1]) == MODE_STOP |-> cnt_r == 16'h0000 && !irq_r)
		else $error("Stopped timer kept a count or raised a request");
	a_match_irq: assert property (@(posedge clk_sys) disable iff (srst)
		run && tick && match |=> irq_r)
		else $error("Compare match raised no request");
	a_match_clear: assert property (@(posedge clk_sys) disable iff (srst)
		clr_match && tick && match && !cpu_wr |=> cnt_r == 16'h0000)
		else $error("Clear-on-match did not clear the count");
	a_edge_clear: assert property (@(posedge clk_sys) disable iff (srst)
		clr_edge && ti_edge && !cpu_wr |=> cnt_r == 16'h0000)
		else $error("Clear-on-edge did not clear the count");
	a_ovf_sets: assert property (@(posedge clk_sys) disable iff (srst)
		run && tick && cnt_r == CNT_MAX && !clr_match |=> tmc_r[TMC_OVF])
		else $error("Overflow not flagged");
	a_toc_cmd_zero: assert property (@(posedge clk_sys) disable iff (srst)
		$past(cpu_rd) && $past(cpu_addr) == ADDR_TOC |-> rd_r[7:3] == 5'h00)
		else $error("Flip-flop command bits read non-zero");
	a_ems_low_zero: assert property (@(posedge clk_sys) disable iff (srst)
		ems_r[1:0] == 2'h0)
		else $error("Edge register low bits not zero");
	a_pin_dir: assert property (@(posedge clk_sys) disable iff (srst)
		##1 timer_output_oe_n == $past(p3dir_r[0]))
		else $error("Pin enable does not follow direction bit");
	a_edge_toggle: assert property (@(posedge clk_sys) disable iff (srst)
		run && !pwm && toc_r[TOC_INV_EN] && !tick && ti_edge && !out_on_edge && !cpu_wr
		|=> ff_r == $past(ff_r))
		else $error("Output changed on edge without edge timing");
endmodule

// *** tmr16_pulse_src.sv ***
// Partner model: pulse source on the shared timer input and both interrupt pins
`timescale 1ns/1ps
module tmr16_pulse_src
(
	// Clock
	input  wire logic       clk_sys,
	// Pins: bit0 shared count input, bit1 and bit2 interrupt pins
	output logic      [2:0] pins
);
	// Pins rest low between pulses; they are always driven, never floating
	initial pins = 3'h0;

	// ****************************************************************
	// Pulse generator
	// ****************************************************************
	// Raise the masked pins for width clocks, then hold low for gap clocks.
	// Edges move only just after a clock edge, like a real synchronous source.
	task automatic pulse(input logic [2:0] mask, input int width, input int gap);
		@(posedge clk_sys);
		pins <= mask;
		repeat (width) @(posedge clk_sys);
		pins <= 3'h0;
		repeat (gap) @(posedge clk_sys);
	endtask
endmodule

// *** test_timer16_mode_edge_control.sv ***
// Testbench: self-checking run of the timer mode, output and edge control block
`timescale 1ns/1ps
module test_timer16_mode_edge_control;
	import tmr16_pkg::*;
	localparam int SDIV = 2;          // Short sampling period keeps edge tests quick
	logic        clk_sys;             // System clock, 25 ns
	logic        srst;                // Synchronous reset
	logic [15:0] cpu_addr;            // Register address
	logic        cpu_wr;              // Write strobe
	logic [7:0]  cpu_wmask;           // Write mask
	logic [7:0]  cpu_wdata;           // Write data
	logic        cpu_rd;              // Read strobe
	logic [7:0]  cpu_rdata;           // Read data
	logic        rd_q;                // Read taken on the previous edge
	logic [2:0]  pins;                // Partner pins
	logic        tout;                // Timer output pin
	logic        tout_oe_n;           // Timer output enable, low = driven
	logic        cout;                // Clock output pin
	logic        match_irq;           // Compare match pulse
	logic [2:0]  ext_req;             // Edge request pulses
	logic [7:0]  rq[$];               // Expected read data
	logic [3:0]  iq[$];               // Expected {match, edge requests}
	int          fail_count;          // Mismatches
	int          checks_done;         // Comparisons made
	int          cyc;                 // Cycle counter
	int          last;                // Cycle of the previous match pulse
	int          per;                 // Expected match period, 0 = unchecked
	int          seed;                // Random seed
	int          w;                   // Pulse width
	logic [2:0]  m;                   // Random pin mask

	// Clock: half period 12.5 ns
	initial clk_sys = 1'b0;
	always #12.5 clk_sys = ~clk_sys;

	tmr16_pulse_src i_src (.clk_sys(clk_sys), .pins(pins));

	tmr16_ctrl #(.SAMPLE_DIV(SDIV)) i_dut (
		.clk_sys(clk_sys), .srst(srst), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
		.cpu_wmask(cpu_wmask), .cpu_wdata(cpu_wdata), .cpu_rd(cpu_rd),
		.cpu_rdata(cpu_rdata), .count_input_pin(pins[0]), .ext_irq_one_input(pins[1]),
		.ext_irq_two_input(pins[2]), .timer_output_pin(tout),
		.timer_output_oe_n(tout_oe_n), .clock_output_pin(cout), .compare_match_irq(match_irq),
		.ext_irq_req(ext_req));

	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	// One comparison; unknowns never pass thanks to case equality
	task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
		checks_done++;
		if (g !== e)
		begin
			fail_count++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask

	// Register write held for exactly one taking edge
	task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [7:0] k);
		@(posedge clk_sys);
		cpu_addr <= a;
		cpu_wdata <= d;
		cpu_wmask <= k;
		cpu_wr <= 1'b1;
		@(posedge clk_sys);
		cpu_wr <= 1'b0;
	endtask

	// Register read; the monitor compares the data one cycle after the taking edge
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		@(posedge clk_sys);
		cpu_addr <= a;
		cpu_rd <= 1'b1;
		rq.push_back(e);
		@(posedge clk_sys);
		cpu_rd <= 1'b0;
	endtask

	// Verdict; notes still queued mean an expected pulse never came
	task automatic end_of_test;
		cmp("pending", 8'h00, 8'(iq.size()));
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// ****************************************************************
	// Output monitor
	// ****************************************************************
	// Any pulse with no note waiting is a spurious pulse and fails
	always @(posedge clk_sys)
	begin
		cyc <= cyc + 1;
		rd_q <= cpu_rd;
		if (rd_q)
			cmp("rdata", rq.pop_front(), cpu_rdata);
		if ({match_irq, ext_req} !== 4'h0)
		begin
			if (iq.size() == 0)
				cmp("irq", 8'h00, {4'h0, match_irq, ext_req});
			else
				cmp("irq", {4'h0, iq.pop_front()}, {4'h0, match_irq, ext_req});
			if (match_irq === 1'b1 && per != 0 && last != 0)
				cmp("period", per[7:0], 8'(cyc - last));
			if (match_irq === 1'b1)
				last <= cyc;
		end
	end

	// Watchdog: the run needs about 70000 cycles
	initial
	begin
		repeat (80000) @(posedge clk_sys);
		fail_count++;
		end_of_test;
	end

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial
	begin
		{srst, cpu_wr, cpu_rd, rd_q} = 4'h8;
		{cpu_addr, cpu_wdata, cpu_wmask} = 32'h0000_0000;
		{fail_count, checks_done, cyc, last, per} = '0;
		seed = 88;
		repeat (3) @(posedge clk_sys);
		srst <= 1'b0;
		// Reset values and an unmapped address
		rd(ADDR_TCS, 8'h00);
		rd(ADDR_TMC, 8'h00);
		rd(ADDR_TOC, 8'h00);
		rd(ADDR_P3DIR, 8'hFF);
		rd(ADDR_EMS, 8'h00);
		rd(16'hFF00, 8'h00);
		// Edge register takes byte writes only, low bits stay zero
		wr(ADDR_EMS, 8'hFF, 8'h04);
		rd(ADDR_EMS, 8'h00);
		wr(ADDR_EMS, 8'hFF, 8'hFF);
		rd(ADDR_EMS, 8'hFC);
		// Flip-flop commands read back zero
		wr(ADDR_TOC, 8'h1F, 8'hFF);
		rd(ADDR_TOC, 8'h07);
		wr(ADDR_TOC, 8'h00, 8'hFF);
		// Every edge selection on all three pins, timer stopped
		for (int s = 0; s < 4; s++)
		begin
			wr(ADDR_EMS, {s[1:0], s[1:0], s[1:0], 2'b00}, 8'hFF);
			repeat (3)
			begin
				m = 3'($random(seed) & 7);
				w = 12 + ($random(seed) & 7);
				if (m != 0 && s[0])
					iq.push_back({1'b0, m});
				if (m != 0 && (s == 0 || s == 3))
					iq.push_back({1'b0, m});
				i_src.pulse(m, w, 16);
			end
			// A one-clock glitch is never seen on two samples
			i_src.pulse(3'h7, 1, 16);
		end
		// Clear and restart on match: period is compare plus one ticks
		wr(ADDR_CMP_LO, 8'h10, 8'hFF);
		wr(ADDR_CMP_HI, 8'h00, 8'hFF);
		wr(ADDR_TCS, 8'h10, 8'hFF);
		per = 17;
		repeat (3) iq.push_back(4'h8);
		wr(ADDR_TMC, 8'h0C, 8'hFF);
		repeat (56) @(posedge clk_sys);
		wr(ADDR_TMC, 8'h00, 8'hFF);
		per = 0;
		rd(ADDR_CNT_LO, 8'h00);
		// PWM: mode first, then pulse data, pin driven once direction is cleared
		wr(ADDR_TOC, 8'h01, 8'hFF);
		wr(ADDR_TMC, 8'h02, 8'hFF);
		wr(ADDR_CMP_HI, 8'h80, 8'hFF);
		wr(ADDR_CMP_LO, 8'h00, 8'hFF);
		wr(ADDR_P3DIR, 8'hFE, 8'hFF);
		repeat (4) @(negedge clk_sys);
		cmp("pin", 8'h01, {7'h0, tout});
		cmp("oe_n", 8'h00, {7'h0, tout_oe_n});
		wr(ADDR_TMC, 8'h00, 8'hFF);
		// Free-running to the top: one match, then the overflow flag
		wr(ADDR_CMP_LO, 8'hFF, 8'hFF);
		wr(ADDR_CMP_HI, 8'hFF, 8'hFF);
		iq.push_back(4'h8);
		wr(ADDR_TMC, 8'h04, 8'hFF);
		repeat (65545) @(posedge clk_sys);
		rd(ADDR_TMC, 8'h05);
		wr(ADDR_TMC, 8'h00, 8'hFF);
		// Clock output: rate bits first, then the enable bit alone
		wr(ADDR_TCS, 8'h01, 8'h0F);
		wr(ADDR_TCS, 8'h80, 8'h80);
		repeat (2) @(negedge clk_sys);
		w = 0;
		m[0] = cout;
		// Rate 1 toggles every 4 clocks, so 16 clocks hold exactly 4 toggles
		repeat (16)
		begin
			@(negedge clk_sys);
			if (cout !== m[0])
				w++;
			m[0] = cout;
		end
		cmp("clk_out", 8'h04, 8'(w));
		wr(ADDR_TCS, 8'h00, 8'h80);
		repeat (2) @(negedge clk_sys);
		cmp("clk_out", 8'h00, {7'h0, cout});
		// Count on input edges; the output also toggles on each edge
		wr(ADDR_TCS, 8'h00, 8'h70);
		wr(ADDR_EMS, 8'h54, 8'hFF);
		wr(ADDR_TOC, 8'h0D, 8'hFF);
		wr(ADDR_TMC, 8'h06, 8'hFF);
		repeat (3)
		begin
			iq.push_back(4'h1);
			i_src.pulse(3'h1, 12, 16);
		end
		rd(ADDR_CNT_LO, 8'h03);
		@(negedge clk_sys);
		cmp("pin", 8'h01, {7'h0, tout});
		// Clear on input edge: a count above 255 falls back near zero
		wr(ADDR_TMC, 8'h00, 8'hFF);
		wr(ADDR_TCS, 8'h40, 8'h70);
		wr(ADDR_TMC, 8'h08, 8'hFF);
		repeat (2100) @(posedge clk_sys);
		rd(ADDR_CNT_HI, 8'h01);
		// Odd number of edges: an edge toggle here would flip the pin
		repeat (3)
		begin
			iq.push_back(4'h1);
			i_src.pulse(3'h1, 12, 16);
		end
		rd(ADDR_CNT_HI, 8'h00);
		@(negedge clk_sys);
		cmp("pin", 8'h01, {7'h0, tout});
		wr(ADDR_TMC, 8'h00, 8'hFF);
		repeat (4) @(posedge clk_sys);
		end_of_test;
	end
endmodule
